// ==== inc/bscan_consts.svh ====
// Constants for the boundary scan chain: layout, opcodes and counts.
`ifndef BSCAN_CONSTS_SVH
`define BSCAN_CONSTS_SVH

`define BSC_LEN 188
`define BSC_LAST 187
`define BSC_CTL_N 5
`define BSC_IN_N 25
`define BSC_OUT_N 30
`define BSC_BIDIR_N 64
`define BSC_PIN_OUTS 94
`define BSC_PIN_INS 89
`define BSC_IN_BASE 5
`define BSC_OUT_BASE 30
`define BSC_BIDIR_BASE 60
`define BSC_GRP_SIZE 16
`define BSC_OUT_GRP 4

`define INSTR_EXTEST 3'h0
`define INSTR_FLOAT 3'h1
`define INSTR_SAMPLE 3'h2
`define INSTR_CLAMP 3'h4
`define INSTR_BYPASS 3'h7

`define EXIT_CNT_ZERO 4'h0
`define EXIT_CNT_ONE 4'h1
`define EXIT_RESET_WINDOW 4'h8
`define EXIT_RESET_FIRE 4'ha

`endif

// ==== inc/bscan_pkg.sv ====
// Types shared by the boundary scan chain.
package bscan_pkg;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_WAIT = 2'b01
    } exit_seq_type;

endpackage

// ==== hdl/scan_cell.sv ====
// One boundary scan cell: serial stage plus parallel hold latch.
`timescale 1ns/100ps
module scan_cell #(
    parameter bit CLEARABLE = 1'b0
) (
    input wire logic tck, // Test clock.
    input wire logic rst, // Synchronous reset, tck domain.
    input wire logic clear, // Test-logic-reset clear for control cells.
    input wire logic capture_en, // Capture-DR with chain selected.
    input wire logic shift_en, // Shift-DR with chain selected.
    input wire logic update_en, // Update-DR with chain selected.
    input wire logic capture_val, // Value loaded on capture.
    input wire logic serial_in, // Stage nearer the data input.
    output logic serial_out, // Serial stage.
    output logic hold // Parallel hold latch.
);

    logic sh_r;
    logic sh_nxt;
    logic hold_r;
    logic hold_nxt;

    always_comb begin
        sh_nxt = sh_r;
        hold_nxt = hold_r;
        if (capture_en) begin
            sh_nxt = capture_val;
        end else if (shift_en) begin
            sh_nxt = serial_in;
        end
        // The hold latch is left alone while shifting.
        if (CLEARABLE && clear) begin
            hold_nxt = 1'b0;
        end else if (update_en) begin
            hold_nxt = sh_r;
        end
    end

    always_ff @(posedge tck) begin
        if (rst) begin
            sh_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign serial_out = sh_r;
    assign hold = hold_r;

endmodule

// ==== hdl/boundary_scan_chain.sv ====
// Boundary scan data register with pin muxing and reset restrictions.
`timescale 1ns/100ps
`include "bscan_consts.svh"
module boundary_scan_chain (
    input wire logic clk, // Bus clock.
    input wire logic rst, // Power-up reset, clk domain.
    input wire logic tck, // Test clock, never gated.
    input wire logic tap_in_reset, // TAP is in test-logic-reset.
    input wire logic tap_capture_dr, // TAP is in capture-DR.
    input wire logic tap_shift_dr, // TAP is in shift-DR.
    input wire logic tap_update_dr, // TAP is in update-DR.
    input wire logic tap_shift_ir, // TAP is in shift-IR.
    input wire logic tap_update_ir, // TAP is in update-IR.
    input wire logic [2:0] instr, // Latched decoded instruction.
    input wire logic tdi, // Serial test data input.
    input wire logic ir_serial, // Instruction register serial out.
    input wire logic bypass_serial, // Bypass register serial out.
    input wire logic [`BSC_PIN_OUTS-1:0] func_out, // System output data.
    input wire logic [`BSC_PIN_OUTS-1:0] func_oe, // System output enables.
    input wire logic [`BSC_PIN_INS-1:0] pin_in, // Pin input levels.
    input wire logic external_reset_input, // External reset pin.
    input wire logic low_power_halt, // System is in low-power halt.
    output logic tdo, // Serial test data output.
    output logic tdo_oe, // Drive enable for tdo.
    output logic [`BSC_PIN_OUTS-1:0] pin_out, // Pin output data.
    output logic [`BSC_PIN_OUTS-1:0] pin_oe, // Pin output enables.
    output logic tap_hold_reset, // Holds TAP in test-logic-reset.
    output logic sys_reset, // Internal system reset request.
    output logic reset_start, // Pulse: begin normal reset.
    output logic deep_sleep_en // Lowest power level allowed.
);

    // Test clock domain.
    logic rst_t1_r;
    logic rst_t2_r;
    logic [`BSC_PIN_OUTS-1:0] fo_t1_r;
    logic [`BSC_PIN_OUTS-1:0] fo_t2_r;
    logic [`BSC_PIN_INS-1:0] pi_t1_r;
    logic [`BSC_PIN_INS-1:0] pi_t2_r;
    logic evt_tgl_r;
    logic evt_tgl_nxt;
    logic tdo_r;
    logic tdo_nxt;
    logic tdo_oe_r;
    logic tdo_oe_nxt;
    logic chain_sel;
    logic cap_en;
    logic sh_en;
    logic upd_en;
    logic ctl_clr;
    logic [`BSC_LAST:0] cell_so;
    logic [`BSC_LAST:0] cell_hold;
    logic [`BSC_PIN_OUTS-1:0] out_hold;
    logic [`BSC_CTL_N-1:0] ctl_hold;

    // Power-up reset reaches the test logic and the TAP.
    always_ff @(posedge tck) begin
        rst_t1_r <= rst;
        rst_t2_r <= rst_t1_r;
    end

    assign tap_hold_reset = rst_t2_r;

    always_ff @(posedge tck) begin
        fo_t1_r <= func_out;
        fo_t2_r <= fo_t1_r;
        pi_t1_r <= pin_in;
        pi_t2_r <= pi_t1_r;
    end

    always_comb begin
        chain_sel = (instr == `INSTR_EXTEST) || (instr == `INSTR_SAMPLE);
        cap_en = tap_capture_dr && chain_sel;
        sh_en = tap_shift_dr && chain_sel;
        upd_en = tap_update_dr && chain_sel;
        ctl_clr = tap_in_reset || rst_t2_r;
    end

    // The chain: control, input-only, output-only, then bidir pairs.
    for (genvar i = 0; i < `BSC_LEN; i++) begin : g_cell
        logic cap_v;
        logic ser_in;
        if (i < `BSC_IN_BASE) begin : g_ctl
            assign cap_v = cell_hold[i];
        end else if (i < `BSC_OUT_BASE) begin : g_in
            assign cap_v = pi_t2_r[i - `BSC_IN_BASE];
        end else if (i < `BSC_BIDIR_BASE) begin : g_out
            assign cap_v = fo_t2_r[i - `BSC_OUT_BASE];
        end else if (((i - `BSC_BIDIR_BASE) % 2) == 0) begin : g_bin
            assign cap_v = pi_t2_r[`BSC_IN_N + (i - `BSC_BIDIR_BASE) / 2];
        end else begin : g_bout
            assign cap_v = fo_t2_r[`BSC_OUT_N + (i - `BSC_BIDIR_BASE) / 2];
        end
        if (i == `BSC_LAST) begin : g_head
            assign ser_in = tdi;
        end else begin : g_link
            assign ser_in = cell_so[i + 1];
        end
        scan_cell #(
            .CLEARABLE(i < `BSC_IN_BASE)
        ) u_cell (
            .tck(tck),
            .rst(rst_t2_r),
            .clear(ctl_clr),
            .capture_en(cap_en),
            .shift_en(sh_en),
            .update_en(upd_en),
            .capture_val(cap_v),
            .serial_in(ser_in),
            .serial_out(cell_so[i]),
            .hold(cell_hold[i])
        );
    end

    // Gather output hold latches per pin and the control cells.
    for (genvar p = 0; p < `BSC_PIN_OUTS; p++) begin : g_ohold
        if (p < `BSC_OUT_N) begin : g_only
            assign out_hold[p] = cell_hold[`BSC_OUT_BASE + p];
        end else begin : g_bi
            assign out_hold[p] =
                cell_hold[`BSC_BIDIR_BASE + 2 * (p - `BSC_OUT_N) + 1];
        end
    end
    assign ctl_hold = cell_hold[`BSC_CTL_N-1:0];

    // Toggle marks a change of hold latches or instruction.
    // A clear toggles only when it changes a hold, so a burst of clears
    // cannot toggle twice between two bus clock edges and go unseen.
    always_comb begin
        evt_tgl_nxt = evt_tgl_r;
        if (upd_en || tap_update_ir || (ctl_clr && (ctl_hold != '0))) begin
            evt_tgl_nxt = ~evt_tgl_r;
        end
    end

    always_ff @(posedge tck) begin
        if (rst_t2_r) begin
            evt_tgl_r <= 1'b0;
        end else begin
            evt_tgl_r <= evt_tgl_nxt;
        end
    end

    // Serial output changes on the falling test clock edge.
    always_comb begin
        tdo_oe_nxt = tap_shift_ir || tap_shift_dr;
        if (tap_shift_ir) begin
            tdo_nxt = ir_serial;
        end else if (chain_sel) begin
            tdo_nxt = cell_so[0];
        end else begin
            tdo_nxt = bypass_serial;
        end
    end

    always_ff @(negedge tck) begin
        if (rst_t2_r) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_r <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;

    // Bus clock domain.
    logic tgl_c1_r;
    logic tgl_c2_r;
    logic tgl_c3_r;
    logic tlr_c1_r;
    logic tlr_c2_r;
    logic xr_c1_r;
    logic xr_c2_r;
    logic [2:0] instr_c_r;
    logic [2:0] instr_c_nxt;
    logic [`BSC_PIN_OUTS-1:0] ohold_c_r;
    logic [`BSC_PIN_OUTS-1:0] ohold_c_nxt;
    logic [`BSC_CTL_N-1:0] ctl_c_r;
    logic [`BSC_CTL_N-1:0] ctl_c_nxt;
    logic [`BSC_PIN_OUTS-1:0] pin_out_r;
    logic [`BSC_PIN_OUTS-1:0] pin_out_nxt;
    logic [`BSC_PIN_OUTS-1:0] pin_oe_r;
    logic [`BSC_PIN_OUTS-1:0] pin_oe_nxt;
    logic [`BSC_PIN_OUTS-1:0] grp_en;
    logic extest_c;
    logic drive_bs;
    logic float_c;
    logic extest_d_r;
    logic sys_reset_r;
    logic sys_reset_nxt;
    logic deep_r;
    logic deep_nxt;
    logic start_r;
    logic start_nxt;
    logic [3:0] exit_cnt_r;
    logic [3:0] exit_cnt_nxt;
    bscan_pkg::exit_seq_type seq_r;
    bscan_pkg::exit_seq_type seq_nxt;

    always_ff @(posedge clk) begin
        tgl_c1_r <= evt_tgl_r;
        tgl_c2_r <= tgl_c1_r;
        tgl_c3_r <= tgl_c2_r;
        tlr_c1_r <= tap_in_reset;
        tlr_c2_r <= tlr_c1_r;
        xr_c1_r <= external_reset_input;
        xr_c2_r <= xr_c1_r;
    end

    // Hold latches and instruction are static once the toggle is seen.
    always_comb begin
        instr_c_nxt = instr_c_r;
        ohold_c_nxt = ohold_c_r;
        ctl_c_nxt = ctl_c_r;
        if (tgl_c2_r != tgl_c3_r) begin
            instr_c_nxt = instr;
            ohold_c_nxt = out_hold;
            ctl_c_nxt = ctl_hold;
        end
    end

    for (genvar p = 0; p < `BSC_PIN_OUTS; p++) begin : g_grp
        if (p < `BSC_OUT_N) begin : g_tri
            assign grp_en[p] = ctl_c_r[`BSC_OUT_GRP];
        end else begin : g_bi
            assign grp_en[p] = ctl_c_r[(p - `BSC_OUT_N) / `BSC_GRP_SIZE];
        end
    end

    always_comb begin
        extest_c = (instr_c_r == `INSTR_EXTEST);
        float_c = (instr_c_r == `INSTR_FLOAT);
        drive_bs = extest_c || (instr_c_r == `INSTR_CLAMP);
        if (drive_bs) begin
            pin_out_nxt = ohold_c_r;
            pin_oe_nxt = grp_en;
        end else if (float_c) begin
            pin_out_nxt = func_out;
            pin_oe_nxt = '0;
        end else begin
            pin_out_nxt = func_out;
            pin_oe_nxt = func_oe;
        end
        sys_reset_nxt = extest_c || float_c;
        // Test clock is never gated here, only deep sleep is withheld.
        deep_nxt = low_power_halt && tlr_c2_r;
    end

    // Exit from external test starts a wait for the reset pin.
    always_comb begin
        seq_nxt = seq_r;
        exit_cnt_nxt = exit_cnt_r;
        start_nxt = 1'b0;
        case (seq_r)
            bscan_pkg::RS_IDLE: begin
                if (extest_d_r && !extest_c) begin
                    seq_nxt = bscan_pkg::RS_WAIT;
                    exit_cnt_nxt = `EXIT_CNT_ONE;
                end
            end
            bscan_pkg::RS_WAIT: begin
                if (xr_c2_r && exit_cnt_r <= `EXIT_RESET_WINDOW) begin
                    seq_nxt = bscan_pkg::RS_IDLE;
                    exit_cnt_nxt = `EXIT_CNT_ZERO;
                end else if (exit_cnt_r == `EXIT_RESET_FIRE) begin
                    seq_nxt = bscan_pkg::RS_IDLE;
                    exit_cnt_nxt = `EXIT_CNT_ZERO;
                    start_nxt = 1'b1;
                end else begin
                    exit_cnt_nxt = exit_cnt_r + `EXIT_CNT_ONE;
                end
            end
            default: begin
                seq_nxt = bscan_pkg::RS_IDLE;
                exit_cnt_nxt = `EXIT_CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            instr_c_r <= `INSTR_BYPASS;
            ohold_c_r <= '0;
            ctl_c_r <= '0;
            pin_out_r <= '0;
            pin_oe_r <= '0;
            extest_d_r <= 1'b0;
            sys_reset_r <= 1'b0;
            deep_r <= 1'b0;
            start_r <= 1'b0;
            exit_cnt_r <= `EXIT_CNT_ZERO;
            seq_r <= bscan_pkg::RS_IDLE;
        end else begin
            instr_c_r <= instr_c_nxt;
            ohold_c_r <= ohold_c_nxt;
            ctl_c_r <= ctl_c_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            extest_d_r <= extest_c;
            sys_reset_r <= sys_reset_nxt;
            deep_r <= deep_nxt;
            start_r <= start_nxt;
            exit_cnt_r <= exit_cnt_nxt;
            seq_r <= seq_nxt;
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign sys_reset = sys_reset_r;
    assign deep_sleep_en = deep_r;
    assign reset_start = start_r;

endmodule

// ==== verif/bscan_chk_assertions.sv ====
// Port assertions for the boundary scan chain.
`timescale 1ns/100ps
`include "bscan_consts.svh"
module bscan_chk (
    input wire logic clk, // Bus clock.
    input wire logic rst, // Power-up reset.
    input wire logic tck, // Test clock.
    input wire logic tap_in_reset, // Test-logic-reset.
    input wire logic tap_shift_dr, // Shift-DR.
    input wire logic tap_shift_ir, // Shift-IR.
    input wire logic [2:0] instr, // Instruction.
    input wire logic low_power_halt, // Halt.
    input wire logic tdo_oe, // Data out enable.
    input wire logic [`BSC_PIN_OUTS-1:0] pin_out, // Pin data.
    input wire logic [`BSC_PIN_OUTS-1:0] pin_oe, // Pin enables.
    input wire logic tap_hold_reset, // TAP hold.
    input wire logic sys_reset, // System reset.
    input wire logic reset_start, // Reset pulse.
    input wire logic deep_sleep_en // Deep sleep.
);
    // Counts bus clocks since the system reset request last stood high.
    logic [4:0] gap_r;
    logic [4:0] gap_nxt;
    always_comb begin
        gap_nxt = gap_r + {4'h0, gap_r != 5'h1f};
        if (sys_reset) gap_nxt = 5'h00;
    end
    always_ff @(posedge clk) gap_r <= rst ? 5'h1f : gap_nxt;

    property p_oe_idle;
        @(posedge tck) disable iff (rst || tap_hold_reset)
        !tap_shift_dr && !tap_shift_ir |-> !tdo_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("tdo enabled outside shift");
    property p_oe_shift;
        @(posedge tck) disable iff (rst || tap_hold_reset)
        tap_shift_dr |-> tdo_oe;
    endproperty
    a_oe_shift: assert property (p_oe_shift)
        else $error("tdo not enabled in shift");
    property p_hold;
        @(posedge tck) rst [*3] |-> tap_hold_reset;
    endproperty
    a_hold: assert property (p_hold) else $error("TAP not held");
    property p_quiet;
        @(posedge clk) rst [*2] |-> pin_oe == '0 && !sys_reset && !reset_start;
    endproperty
    a_quiet: assert property (p_quiet) else $error("active in reset");
    property p_deep_on;
        @(posedge clk) disable iff (rst)
        (low_power_halt && tap_in_reset) [*5] |-> deep_sleep_en;
    endproperty
    a_deep_on: assert property (p_deep_on)
        else $error("deep sleep refused");
    property p_deep_off;
        @(posedge clk) disable iff (rst) !tap_in_reset [*5] |-> !deep_sleep_en;
    endproperty
    a_deep_off: assert property (p_deep_off)
        else $error("deep sleep outside reset");
    property p_pulse;
        @(posedge clk) disable iff (rst)
        reset_start |-> gap_r >= 5'h07 && gap_r <= 5'h0c ##1 !reset_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("bad reset pulse");
    property p_float;
        @(posedge clk) disable iff (rst)
        (instr == `INSTR_FLOAT) [*8] |-> pin_oe == '0 && sys_reset;
    endproperty
    a_float: assert property (p_float) else $error("float not held");
    property p_clamp;
        @(posedge clk) disable iff (rst)
        (instr == `INSTR_CLAMP) [*8] |-> $stable(pin_out) && $stable(pin_oe);
    endproperty
    a_clamp: assert property (p_clamp) else $error("pins moved");
    c_pulse: cover property (@(posedge clk) reset_start);
    c_deep: cover property (@(posedge clk) deep_sleep_en);
    c_shift: cover property (@(posedge tck) tdo_oe);
endmodule

bind boundary_scan_chain bscan_chk i_chk (
    .clk, .rst, .tck, .tap_in_reset, .tap_shift_dr, .tap_shift_ir, .instr,
    .low_power_halt, .tdo_oe, .pin_out, .pin_oe, .tap_hold_reset,
    .sys_reset, .reset_start, .deep_sleep_en
);

// ==== verif/scan_master.sv ====
// Board test controller model: drives the test port and collects tdo.
`timescale 1ns/100ps
module scan_master (
    output logic tck, // Test clock, still between frames.
    output logic tap_capture_dr, // Capture-DR.
    output logic tap_shift_dr, // Shift-DR.
    output logic tap_update_dr, // Update-DR.
    output logic tap_update_ir, // Update-IR.
    output logic [2:0] instr, // Instruction.
    output logic tdi, // Serial data to the chain.
    input wire logic tdo // Serial data back.
);
    logic run = 1'h0;

    initial begin
        {tck, tap_capture_dr, tap_shift_dr, tap_update_dr} = 4'h0;
        {tap_update_ir, instr, tdi} = 5'h0f;
        #2.3;
        forever #6 tck = run ? ~tck : 1'h0;
    end

    task automatic ticks(input int n);
        run = 1'h1;
        repeat (n) @(posedge tck);
        #1 run = 1'h0;
    endtask

    task automatic setir(input logic [2:0] code);
        run = 1'h1;
        @(posedge tck) #1 {instr, tap_update_ir} = {code, 1'h1};
        @(posedge tck) #1 tap_update_ir = 1'h0;
        ticks(2);
    endtask

    // Idle tdi sits high as its pull-up would leave it.
    task automatic scan(input logic [187:0] pat, output logic [187:0] got);
        logic [187:0] q;
        q = pat;
        run = 1'h1;
        @(posedge tck) #1 tap_capture_dr = 1'h1;
        @(posedge tck) #1 {tap_capture_dr, tap_shift_dr, tdi} = {2'h1, q[0]};
        for (int i = 0; i < 188; i++) begin
            @(posedge tck) got[i] = tdo;
            #1 {tap_shift_dr, tap_update_dr} = {i < 187, i == 187};
            q = {1'h1, q[187:1]};
            tdi = q[0];
        end
        @(posedge tck) #1 tap_update_dr = 1'h0;
        ticks(2);
    endtask
endmodule

// ==== verif/boundary_scan_chain_test.sv ====
// Self-checking bench for the boundary scan chain.
`timescale 1ns/100ps
`include "bscan_consts.svh"
module boundary_scan_chain_test;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic tap_in_reset = 1'h1;
    logic low_power_halt = 1'h0;
    logic bypass_serial = 1'h0;
    logic external_reset_input = 1'h0;
    logic tap_shift_ir = 1'h0;
    logic ir_serial = 1'h0;
    logic [`BSC_PIN_OUTS-1:0] func_out = '0;
    logic [`BSC_PIN_OUTS-1:0] func_oe = '0;
    logic [`BSC_PIN_INS-1:0] pin_in = '0;
    logic tck, tap_capture_dr, tap_shift_dr, tap_update_dr, tap_update_ir;
    logic tdi, tdo, tdo_oe, tap_hold_reset, sys_reset, reset_start;
    logic deep_sleep_en;
    logic [2:0] instr;
    logic [`BSC_PIN_OUTS-1:0] pin_out, pin_oe;
    logic [187:0] pat, got, hold;
    int seed = 32'he55d_54ec;
    int miscompares = 0;
    int comparisons = 0;
    int pulses = 0;
    int cycles = 0;

    boundary_scan_chain i_dut (
        .clk, .rst, .tck, .tap_in_reset, .tap_capture_dr, .tap_shift_dr,
        .tap_update_dr, .tap_shift_ir, .tap_update_ir, .instr, .tdi,
        .ir_serial, .bypass_serial, .func_out, .func_oe, .pin_in,
        .external_reset_input, .low_power_halt, .tdo, .tdo_oe, .pin_out,
        .pin_oe, .tap_hold_reset, .sys_reset, .reset_start, .deep_sleep_en
    );
    scan_master i_master (
        .tck, .tap_capture_dr, .tap_shift_dr, .tap_update_dr, .tap_update_ir,
        .instr, .tdi, .tdo
    );

    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (reset_start === 1'h1) pulses++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    task automatic chk(input logic [187:0] act, input logic [187:0] exp);
        comparisons++;
        if (act !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask

    function automatic logic [191:0] rbits();
        for (int i = 0; i < 6; i++) rbits[32*i +: 32] = $random(seed);
    endfunction

    task automatic rnd();
        @(negedge clk);
        func_out = 94'(rbits());
        func_oe = 94'(rbits());
        pin_in = 89'(rbits());
        pat = 188'(rbits());
        i_master.ticks(3);
    endtask

    // Captured image: control holds, then input, output and bidir cells.
    function automatic logic [187:0] cap_exp(input logic [4:0] ctl);
        cap_exp = {128'h0, func_out[29:0], pin_in[24:0], ctl};
        for (int j = 0; j < 64; j++) begin
            cap_exp[60+2*j] = pin_in[25+j];
            cap_exp[61+2*j] = func_out[30+j];
        end
    endfunction

    // Pins driven from holds: {enables, data}.
    function automatic logic [187:0] pins_exp(input logic [187:0] h);
        for (int p = 0; p < 94; p++) begin
            pins_exp[p] = h[p < 30 ? 30 + p : 2 * p + 1];
            pins_exp[94+p] = h[p < 30 ? 4 : (p - 30) / 16];
        end
    endfunction

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        fork
            i_master.ticks(8);
            clks(9);
        join
        chk({pin_oe, sys_reset, reset_start, tap_hold_reset}, 1);
        clks(1);
        rst = 1'h0;
        i_master.ticks(4);
        clks(5);
        chk(deep_sleep_en, 0);
        low_power_halt = 1'h1;
        clks(5);
        chk({tap_hold_reset, deep_sleep_en}, 1);
        tap_in_reset = 1'h0;
        clks(6);
        chk(deep_sleep_en, 0);
        i_master.setir(`INSTR_SAMPLE);
        rnd();
        i_master.scan(pat, got);
        chk(got, cap_exp(5'h00));
        clks(2);
        chk({pin_oe, pin_out}, {func_oe, func_out});
        hold = pat;
        i_master.setir(`INSTR_EXTEST);
        clks(8);
        chk(sys_reset, 1);
        chk({pin_oe, pin_out}, pins_exp(hold));
        rnd();
        i_master.scan(pat, got);
        chk(got, cap_exp(hold[4:0]));
        clks(8);
        chk({pin_oe, pin_out}, pins_exp(pat));
        hold = pat;
        hold[4:0] = 5'h00;
        tap_in_reset = 1'h1;
        i_master.ticks(2);
        clks(1);
        tap_in_reset = 1'h0;
        clks(8);
        chk({pin_oe, pin_out}, pins_exp(hold));
        pulses = 0;
        i_master.setir(`INSTR_CLAMP);
        rnd();
        clks(20);
        chk({pin_oe, pin_out}, pins_exp(hold));
        chk(pulses, 1);
        i_master.setir(`INSTR_FLOAT);
        clks(8);
        chk({pin_oe, sys_reset}, 1);
        i_master.setir(`INSTR_EXTEST);
        clks(8);
        pulses = 0;
        external_reset_input = 1'h1;
        i_master.setir(`INSTR_BYPASS);
        clks(20);
        external_reset_input = 1'h0;
        chk({pulses, sys_reset}, 0);
        bypass_serial = 1'h1;
        i_master.scan(pat, got);
        chk(got, {188{1'h1}});
        clks(1);
        tap_shift_ir = 1'h1;
        i_master.ticks(2);
        clks(1);
        chk({tdo_oe, tdo}, {1'h1, ir_serial});
        fork
            i_master.ticks(3);
            @(posedge tck) #1 tap_shift_ir = 1'h0;
        join
        clks(1);
        chk(tdo_oe, 0);
        results();
    end
endmodule
